/* File: rtl/intc_top.sv */
// Purpose: prioritised interrupt controller with event transfer
// Assumes: single clock, cpu reports running level on cpu_level
// Notes:   node i uses trap number base+i, vector is trap*4
// Function
// - cpu sees accepted request within 8 clocks
// - every node selects vectored or event transfer service
// - event transfer steals exactly one cycle, no vector branch
// - one byte or word moved, source/destination pointers incremented as set
// - transfer counter decrements per service, unchanged in continuous mode
// - outside continuous mode, counter at zero raises vectored interrupt instead of transfer
// - eight channels with own pointers and counter
// - each node has request, enable and priority fields
// - priority field selects among sixteen levels
// - only strictly higher priority preempts running service
// - each node has its own vector
// - fast inputs detect rising, falling or both edges
// - trap number branches to its vector
// - unassigned nodes interrupt when software sets request bit
// - vector offset is four times the trap number
`timescale 1ns/1ps
`include "intc_defines.svh"
module intc_top
#(
  parameter int          N_NODES    = 16,
  parameter int          N_FAST     = 4,
  parameter logic [15:0] HW_MASK    = 16'h0fff
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [N_FAST-1:0]  fast_ext_pin,
  input  wire logic [N_NODES-1:0] periph_req,
  input  wire logic        trap_req,
  input  wire logic [6:0]  trap_num,
  input  wire logic [3:0]  cpu_level,
  input  wire logic        cpu_ack,
  output logic             irq_req,
  output logic      [8:0]  irq_vector,
  output logic      [3:0]  irq_level,
  output logic             xfer_valid,
  output logic      [15:0] xfer_src,
  output logic      [15:0] xfer_dst,
  output logic             xfer_byte,
  output logic             evt_irq
);
  localparam int RESP_MAX = `RESP_CLKS;
  localparam int N_CH     = 8;

  logic [15:0] node_r   [N_NODES];
  logic [15:0] node_nxt [N_NODES];
  logic [15:0] src_r    [N_CH];
  logic [15:0] src_nxt  [N_CH];
  logic [15:0] dst_r    [N_CH];
  logic [15:0] dst_nxt  [N_CH];
  logic [7:0]  cnt_r    [N_CH];
  logic [7:0]  cnt_nxt  [N_CH];
  logic [3:0]  chc_r    [N_CH];
  logic [3:0]  chc_nxt  [N_CH];
  logic [2*N_FAST-1:0] edge_r;
  logic [2*N_FAST-1:0] edge_nxt;
  logic [1:0]  stat_r;
  logic [1:0]  stat_nxt;
  logic [1:0]  mask_r;
  logic [1:0]  mask_nxt;
  logic [15:0] rdata_nxt;
  intc_pkg::state_t state_r;
  intc_pkg::state_t state_nxt;
  logic [8:0]  vec_r;
  logic [8:0]  vec_nxt;
  logic [3:0]  lvl_r;
  logic [3:0]  lvl_nxt;
  logic [3:0]  win_r;
  logic [3:0]  win_nxt;
  logic [2:0]  ch_r;
  logic [2:0]  ch_nxt;
  logic        trapv_r;
  logic        trapv_nxt;
  logic        tpend_r;
  logic        tpend_nxt;
  logic [6:0]  tnum_r;
  logic [6:0]  tnum_nxt;
  logic [15:0] xs_r;
  logic [15:0] xs_nxt;
  logic [15:0] xd_r;
  logic [15:0] xd_nxt;
  logic        xb_r;
  logic        xb_nxt;
  logic [N_NODES-1:0] hw_set;
  logic [N_FAST-1:0]  fast_pulse;
  logic        found;
  logic [3:0]  best_lvl;
  logic [3:0]  best_idx;
  logic [2:0]  best_ch;
  logic        take;
  logic        exp_take;
  logic        et_take;
  logic        clr_win;
  logic [7:0]  cur_cnt;

  genvar g;
  generate
    for (g = 0; g < N_FAST; g++)
    begin : g_fast
      edge_if eif ();
      assign eif.mode = intc_pkg::edge_mode_t'(edge_r[2*g +: 2]);
      assign fast_pulse[g] = eif.pulse;
      edge_detect u_det
      (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (fast_ext_pin[g]),
        .eif   (eif)
      );
    end
  endgenerate

  // fast inputs own the lowest nodes; unassigned nodes get no hw set
  always_comb
  begin
    hw_set = periph_req & HW_MASK[N_NODES-1:0];
    hw_set[N_FAST-1:0] = fast_pulse;
  end

  // downward scan with >= leaves the lowest index on ties
  always_comb
  begin
    found    = 1'b0;
    best_lvl = 4'h0;
    best_idx = 4'h0;
    for (int i = N_NODES - 1; i >= 0; i--)
    begin
      if (node_r[i][`NODE_REQ_BIT] && node_r[i][`NODE_EN_BIT] &&
          (!found || node_r[i][`NODE_LVL_LSB +: 4] >= best_lvl))
      begin
        found    = 1'b1;
        best_lvl = node_r[i][`NODE_LVL_LSB +: 4];
        best_idx = 4'(i);
      end
    end
  end

  assign best_ch  = node_r[best_idx][`NODE_CH_LSB +: 3];
  assign take     = state_r == intc_pkg::ST_IDLE && !tpend_r && found &&
                    best_lvl > cpu_level;
  assign et_take  = take && node_r[best_idx][`NODE_ET_BIT] &&
                    (chc_r[best_ch][`CH_CONT_BIT] ||
                     cnt_r[best_ch] != 8'h00);
  assign exp_take = take && node_r[best_idx][`NODE_ET_BIT] && !et_take;
  assign clr_win  = et_take ||
                    (state_r == intc_pkg::ST_VEC && cpu_ack && !trapv_r);
  assign cur_cnt  = cnt_r[ch_r];

  // control state machine
  always_comb
  begin
    state_nxt = state_r;
    vec_nxt   = vec_r;
    lvl_nxt   = lvl_r;
    win_nxt   = win_r;
    ch_nxt    = ch_r;
    trapv_nxt = trapv_r;
    xs_nxt    = xs_r;
    xd_nxt    = xd_r;
    xb_nxt    = xb_r;
    tpend_nxt = tpend_r;
    tnum_nxt  = tnum_r;
    if (trap_req && !tpend_r)
    begin
      tpend_nxt = 1'b1;
      tnum_nxt  = trap_num;
    end
    case (state_r)
      intc_pkg::ST_IDLE:
      begin
        if (tpend_r)
        begin
          state_nxt = intc_pkg::ST_VEC;
          vec_nxt   = {tnum_r, 2'b00};
          lvl_nxt   = 4'hf;
          trapv_nxt = 1'b1;
          tpend_nxt = trap_req;
          tnum_nxt  = trap_num;
        end
        else if (et_take)
        begin
          state_nxt = intc_pkg::ST_XFER;
          ch_nxt    = best_ch;
          xs_nxt    = src_r[best_ch];
          xd_nxt    = dst_r[best_ch];
          xb_nxt    = chc_r[best_ch][`CH_BYTE_BIT];
        end
        else if (take)
        begin
          state_nxt = intc_pkg::ST_VEC;
          vec_nxt   = {7'(`TRAP_BASE + 7'(best_idx)), 2'b00};
          lvl_nxt   = best_lvl;
          win_nxt   = best_idx;
          trapv_nxt = 1'b0;
        end
      end
      intc_pkg::ST_VEC:
      begin
        if (cpu_ack)
        begin
          state_nxt = intc_pkg::ST_IDLE;
        end
      end
      intc_pkg::ST_XFER:
      begin
        state_nxt = intc_pkg::ST_IDLE;
      end
      default:
      begin
        state_nxt = intc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= intc_pkg::ST_IDLE;
      vec_r   <= 9'h000;
      lvl_r   <= 4'h0;
      win_r   <= 4'h0;
      ch_r    <= 3'h0;
      trapv_r <= 1'b0;
      xs_r    <= 16'h0000;
      xd_r    <= 16'h0000;
      xb_r    <= 1'b0;
      tpend_r <= 1'b0;
      tnum_r  <= 7'h00;
    end
    else
    begin
      state_r <= state_nxt;
      vec_r   <= vec_nxt;
      lvl_r   <= lvl_nxt;
      win_r   <= win_nxt;
      ch_r    <= ch_nxt;
      trapv_r <= trapv_nxt;
      xs_r    <= xs_nxt;
      xd_r    <= xd_nxt;
      xb_r    <= xb_nxt;
      tpend_r <= tpend_nxt;
      tnum_r  <= tnum_nxt;
    end
  end

  // register file; hardware set wins over any clear
  always_comb
  begin
    edge_nxt = edge_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    for (int i = 0; i < N_NODES; i++)
    begin
      node_nxt[i] = node_r[i];
      if (wr && addr == `NODE_BASE + 8'(i))
      begin
        node_nxt[i] = wdata;
      end
      if (clr_win && ((et_take && 4'(i) == best_idx) ||
                      (!et_take && 4'(i) == win_r)))
      begin
        node_nxt[i][`NODE_REQ_BIT] = 1'b0;
      end
      if (hw_set[i])
      begin
        node_nxt[i][`NODE_REQ_BIT] = 1'b1;
      end
    end
    for (int c = 0; c < N_CH; c++)
    begin
      src_nxt[c] = src_r[c];
      dst_nxt[c] = dst_r[c];
      cnt_nxt[c] = cnt_r[c];
      chc_nxt[c] = chc_r[c];
      if (state_r == intc_pkg::ST_XFER && 3'(c) == ch_r)
      begin
        if (chc_r[c][`CH_INCS_BIT])
        begin
          src_nxt[c] = src_r[c] + (xb_r ? 16'h0001 : 16'h0002);
        end
        if (chc_r[c][`CH_INCD_BIT])
        begin
          dst_nxt[c] = dst_r[c] + (xb_r ? 16'h0001 : 16'h0002);
        end
        if (!chc_r[c][`CH_CONT_BIT])
        begin
          cnt_nxt[c] = cnt_r[c] - 8'h01;
        end
      end
      if (wr && addr == `CH_BASE + 8'(4 * c))
      begin
        src_nxt[c] = wdata;
      end
      if (wr && addr == `CH_BASE + 8'(4 * c + 1))
      begin
        dst_nxt[c] = wdata;
      end
      if (wr && addr == `CH_BASE + 8'(4 * c + 2))
      begin
        cnt_nxt[c] = wdata[7:0];
      end
      if (wr && addr == `CH_BASE + 8'(4 * c + 3))
      begin
        chc_nxt[c] = wdata[3:0];
      end
    end
    if (wr && addr == `EDGE_ADDR)
    begin
      edge_nxt = wdata[2*N_FAST-1:0];
    end
    if (wr && addr == `EVT_MASK_ADDR)
    begin
      mask_nxt = wdata[1:0];
    end
    if (wr && addr == `EVT_STAT_ADDR)
    begin
      stat_nxt = stat_r & ~wdata[1:0];
    end
    stat_nxt = stat_nxt | {exp_take, state_r == intc_pkg::ST_XFER};
  end

  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (rd)
    begin
      for (int i = 0; i < N_NODES; i++)
      begin
        if (addr == `NODE_BASE + 8'(i))
        begin
          rdata_nxt = node_r[i];
        end
      end
      for (int c = 0; c < N_CH; c++)
      begin
        if (addr == `CH_BASE + 8'(4 * c))
          rdata_nxt = src_r[c];
        if (addr == `CH_BASE + 8'(4 * c + 1))
          rdata_nxt = dst_r[c];
        if (addr == `CH_BASE + 8'(4 * c + 2))
          rdata_nxt = {8'h00, cnt_r[c]};
        if (addr == `CH_BASE + 8'(4 * c + 3))
          rdata_nxt = {12'h000, chc_r[c]};
      end
      case (addr)
        `EDGE_ADDR:     rdata_nxt = 16'(edge_r);
        `EVT_STAT_ADDR: rdata_nxt = {14'h0000, stat_r};
        `EVT_MASK_ADDR: rdata_nxt = {14'h0000, mask_r};
        `STATE_ADDR:    rdata_nxt = {6'h00, tpend_r, ch_r, win_r, state_r};
        default:        ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < N_NODES; i++)
        node_r[i] <= `NODE_RST;
      for (int c = 0; c < N_CH; c++)
      begin
        src_r[c] <= `CH_RST;
        dst_r[c] <= `CH_RST;
        cnt_r[c] <= 8'h00;
        chc_r[c] <= 4'h0;
      end
      edge_r <= '0;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      rdata  <= 16'h0000;
    end
    else
    begin
      node_r <= node_nxt;
      src_r  <= src_nxt;
      dst_r  <= dst_nxt;
      cnt_r  <= cnt_nxt;
      chc_r  <= chc_nxt;
      edge_r <= edge_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata  <= rdata_nxt;
    end
  end

  assign irq_req    = state_r == intc_pkg::ST_VEC;
  assign irq_vector = vec_r;
  assign irq_level  = lvl_r;
  assign xfer_valid = state_r == intc_pkg::ST_XFER;
  assign xfer_src   = xs_r;
  assign xfer_dst   = xd_r;
  assign xfer_byte  = xb_r;
  assign evt_irq    = |(stat_r & mask_r);

  sequence s_steal;
    xfer_valid ##1 !xfer_valid;
  endsequence
  sequence s_vec_up;
    ##1 irq_req && !trapv_r;
  endsequence

  AST_RESP: assert property (@(posedge clk) disable iff (!rst_n)
    take |-> ##[1:RESP_MAX] (irq_req || xfer_valid))
    else $error("accepted request not presented in time");
  AST_STEAL: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(xfer_valid) |-> s_steal)
    else $error("event transfer longer than one cycle");
  AST_CNT: assert property (@(posedge clk) disable iff (!rst_n)
    xfer_valid && !chc_r[ch_r][`CH_CONT_BIT] |=>
      cur_cnt == $past(cur_cnt) - 8'h01)
    else $error("counter did not decrement");
  AST_CONT: assert property (@(posedge clk) disable iff (!rst_n)
    xfer_valid && chc_r[ch_r][`CH_CONT_BIT] && !wr |=> $stable(cur_cnt))
    else $error("continuous counter changed");
  AST_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    exp_take |-> s_vec_up ##0 (irq_vector == {7'(`TRAP_BASE) +
      7'(win_r), 2'b00}) ##0 !xfer_valid)
    else $error("expired counter did not vector");
  AST_VEC: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req && !trapv_r |-> irq_vector[1:0] == 2'b00 &&
      irq_vector[8:2] == `TRAP_BASE + 7'(win_r))
    else $error("vector not four times trap number");
  AST_PRE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_req) && !trapv_r |-> irq_level > $past(cpu_level))
    else $error("preemption without higher level");
  AST_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req && cpu_ack && !trapv_r && !hw_set[win_r] && !wr |=>
      !node_r[win_r][`NODE_REQ_BIT])
    else $error("request flag not cleared on acceptance");
  AST_TRAP: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == intc_pkg::ST_IDLE && tpend_r |=>
      irq_req && trapv_r && irq_vector == {$past(tnum_r), 2'b00})
    else $error("trap did not vector");
endmodule : intc_top

/* File: rtl/intc_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 16-bit register port, word-indexed addresses
// Notes:   included by the controller top
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH
`define NODE_BASE     8'h00
`define CH_BASE       8'h10
`define EDGE_ADDR     8'h30
`define EVT_STAT_ADDR 8'h31
`define EVT_MASK_ADDR 8'h32
`define STATE_ADDR    8'h33
`define NODE_LVL_LSB  0
`define NODE_EN_BIT   6
`define NODE_REQ_BIT  7
`define NODE_ET_BIT   8
`define NODE_CH_LSB   9
`define CH_BYTE_BIT   0
`define CH_INCS_BIT   1
`define CH_INCD_BIT   2
`define CH_CONT_BIT   3
`define NODE_RST      16'h0000
`define CH_RST        16'h0000
`define TRAP_BASE     7'h18
`define RESP_CLKS     8
`endif

/* File: rtl/intc_pkg.sv */
// Purpose: shared types of the interrupt controller
// Assumes: nothing
// Notes:   states and edge modes
package intc_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_VEC  = 2'b01,
    ST_XFER = 2'b10
  } state_t;
  typedef enum logic [1:0]
  {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;
endpackage : intc_pkg

/* File: rtl/edge_if.sv */
// Purpose: carries edge mode and request pulse of one fast input
// Assumes: same clock on both sides
// Notes:   det drives the pulse, ctl drives the mode
`timescale 1ns/1ps
interface edge_if;
  intc_pkg::edge_mode_t mode;
  logic                 pulse;
  modport det (input mode, output pulse);
  modport ctl (output mode, input pulse);
endinterface : edge_if

/* File: rtl/edge_detect.sv */
// Purpose: synchronise one fast external input and detect edges
// Assumes: pin is asynchronous to clk
// Notes:   two flops before the detector; pulse is one cycle
`timescale 1ns/1ps
module edge_detect
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  edge_if.det       eif
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic pulse_r;
  logic pulse_nxt;

  always_comb
  begin
    case (eif.mode)
      intc_pkg::EDGE_RISE: pulse_nxt = s2_r & ~s3_r;
      intc_pkg::EDGE_FALL: pulse_nxt = ~s2_r & s3_r;
      intc_pkg::EDGE_BOTH: pulse_nxt = s2_r ^ s3_r;
      default:             pulse_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      pulse_r <= 1'b0;
    end
    else
    begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      pulse_r <= pulse_nxt;
    end
  end

  assign eif.pulse = pulse_r;
endmodule : edge_detect

/* File: testbench/cpu_model.sv */
// Purpose: cpu side of the interrupt link, accepts presented vectors
// Assumes: cpu_ack only while irq_req, one cycle long
// Notes:   ack_dly gives prompt or slow acceptance
`timescale 1ns/1ps
module cpu_model
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       irq_req,
  input  wire logic [3:0] ack_dly,
  output logic            cpu_ack
);
  logic [3:0] wait_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r  <= 4'h0;
      cpu_ack <= 1'b0;
    end
    else if (cpu_ack || !irq_req)
    begin
      // drop after one cycle so a stale ack never hits the next request
      wait_r  <= 4'h0;
      cpu_ack <= 1'b0;
    end
    else if (wait_r == ack_dly)
      cpu_ack <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end
endmodule : cpu_model

/* File: testbench/prioritized_interrupt_and_event_transfer_tb.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: default parameters, nodes 12..15 unassigned
// Notes:   register bus and pins driven by nba after rising edge
`timescale 1ns/1ps
module prioritized_interrupt_and_event_transfer_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [3:0]  fast_ext_pin = 4'h0;
  logic [15:0] periph_req = 16'h0000;
  logic        trap_req = 1'b0;
  logic [6:0]  trap_num = 7'h00;
  logic [3:0]  cpu_level = 4'h0;
  logic [3:0]  ack_dly = 4'h0;
  logic        cpu_ack, irq_req, xfer_valid, xfer_byte, evt_irq;
  logic [8:0]  irq_vector;
  logic [3:0]  irq_level;
  logic [15:0] xfer_src, xfer_dst, d;
  int          fails = 0;
  int          comparisons = 0;

  always #20 clk = ~clk;

  intc_top i_intc_top (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fast_ext_pin(fast_ext_pin), .periph_req(periph_req),
    .trap_req(trap_req), .trap_num(trap_num), .cpu_level(cpu_level),
    .cpu_ack(cpu_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .xfer_valid(xfer_valid), .xfer_src(xfer_src),
    .xfer_dst(xfer_dst), .xfer_byte(xfer_byte), .evt_irq(evt_irq));

  cpu_model i_cpu_model (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
    .ack_dly(ack_dly), .cpu_ack(cpu_ack));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic pulse_req(input int i);
    @(posedge clk);
    periph_req[i] <= 1'b1;
    @(posedge clk);
    periph_req <= 16'h0000;
    #1;
  endtask : pulse_req

  // bounded wait: answer must come within 8 clocks of the task call
  task automatic wait_sig(input bit xfer);
    int n;
    n = 0;
    while ((xfer ? xfer_valid : irq_req) !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1 n++;
    end
    check({15'h0, (xfer ? xfer_valid : irq_req)}, 16'h0001);
  endtask : wait_sig

  task automatic wait_done();
    int n;
    n = 0;
    while (irq_req !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    check({15'h0, irq_req}, 16'h0000);
  endtask : wait_done

  task automatic t_reset();
    rd_reg(8'h00, d);
    check(d, 16'h0000);
    rd_reg(8'h1a, d);
    check(d, 16'h0000);
    rd_reg(8'hff, d);
    check(d, 16'h0000);
    check({15'h0, evt_irq}, 16'h0000);
  endtask : t_reset

  task automatic t_vector();
    wr_reg(8'h05, 16'h0043);
    pulse_req(5);
    wait_sig(1'b0);
    check({7'h0, irq_vector}, 16'h0074);
    check({12'h0, irq_level}, 16'h0003);
    wait_done();
    rd_reg(8'h05, d);
    check(d, 16'h0043);
  endtask : t_vector

  task automatic t_prio();
    wr_reg(8'h0e, 16'h0042);
    pulse_req(14);
    repeat (4) @(posedge clk);
    #1 check({15'h0, irq_req}, 16'h0000);
    cpu_level <= 4'h5;
    wr_reg(8'h0c, 16'h00c5);
    wr_reg(8'h0d, 16'h00c5);
    repeat (6) @(posedge clk);
    #1 check({15'h0, irq_req}, 16'h0000);
    cpu_level <= 4'h4;
    wait_sig(1'b0);
    check({7'h0, irq_vector}, 16'h0090);
    wait_done();
    wait_sig(1'b0);
    check({7'h0, irq_vector}, 16'h0094);
    wait_done();
    cpu_level <= 4'h0;
  endtask : t_prio

  task automatic t_xfer();
    wr_reg(8'h04, 16'h0542);
    wr_reg(8'h18, 16'h0100);
    wr_reg(8'h19, 16'h0200);
    wr_reg(8'h1a, 16'h0002);
    wr_reg(8'h1b, 16'h0007);
    wr_reg(8'h32, 16'h0003);
    for (int k = 0; k < 2; k++)
    begin
      pulse_req(4);
      wait_sig(1'b1);
      check(xfer_src, 16'h0100 + 16'(k));
      check(xfer_dst, 16'h0200 + 16'(k));
      check({15'h0, xfer_byte}, 16'h0001);
      @(posedge clk);
      #1 check({14'h0, xfer_valid, irq_req}, 16'h0000);
      rd_reg(8'h1a, d);
      check(d, 16'h0001 - 16'(k));
    end
    check({15'h0, evt_irq}, 16'h0001);
    pulse_req(4);
    wait_sig(1'b0);
    check({7'h0, irq_vector}, 16'h0070);
    wait_done();
    rd_reg(8'h31, d);
    check(d, 16'h0003);
    wr_reg(8'h31, 16'h0001);
    rd_reg(8'h31, d);
    check(d, 16'h0002);
    wr_reg(8'h32, 16'h0000);
    #1 check({15'h0, evt_irq}, 16'h0000);
    wr_reg(8'h31, 16'h0002);
    // continuous: count holds, pointers hold without increment bits
    wr_reg(8'h1a, 16'h0005);
    wr_reg(8'h1b, 16'h0009);
    pulse_req(4);
    wait_sig(1'b1);
    check(xfer_src, 16'h0102);
    rd_reg(8'h1a, d);
    check(d, 16'h0005);
  endtask : t_xfer

  task automatic t_edge();
    for (int m = 1; m < 4; m++)
    begin
      wr_reg(8'h30, 16'(m));
      fast_ext_pin[0] <= 1'b1;
      repeat (6) @(posedge clk);
      rd_reg(8'h00, d);
      check(d, (m != 2) ? 16'h0080 : 16'h0000);
      wr_reg(8'h00, 16'h0000);
      fast_ext_pin[0] <= 1'b0;
      repeat (6) @(posedge clk);
      rd_reg(8'h00, d);
      check(d, (m != 1) ? 16'h0080 : 16'h0000);
      wr_reg(8'h00, 16'h0000);
    end
    wr_reg(8'h00, 16'h0041);
    fast_ext_pin[0] <= 1'b1;
    repeat (4) @(posedge clk);
    wait_sig(1'b0);
    check({7'h0, irq_vector}, 16'h0060);
    wait_done();
  endtask : t_edge

  task automatic t_trap();
    ack_dly <= 4'h5;
    @(posedge clk);
    trap_num <= 7'h2a;
    trap_req <= 1'b1;
    @(posedge clk);
    trap_req <= 1'b0;
    wait_sig(1'b0);
    repeat (3) @(posedge clk);
    #1 check({15'h0, irq_req}, 16'h0001);
    check({7'h0, irq_vector}, 16'h00a8);
    check({12'h0, irq_level}, 16'h000f);
    wait_done();
    ack_dly <= 4'h0;
  endtask : t_trap

  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_vector();
    t_prio();
    t_xfer();
    t_edge();
    t_trap();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
endmodule : prioritized_interrupt_and_event_transfer_tb
